// [core/fpces_exception_unit.sv]
// Purpose: instruction acceptance, bounce and exceptional-state capture of the fp coprocessor
// Assumes: one issue per asserted instr_valid cycle, inputs synchronous to clk
// Notes:   software reaches control, exception, capture and interrupt registers over Avalon-MM
`timescale 1ns/1ns
`include "fpces_regs.svh"
module fpces_exception_unit
   import fpces_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // avalon-mm slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // instruction issue from the host core
   input  wire logic        instr_valid,
   input  wire fpces_word_t instr_word,
   input  wire logic [2:0]  vec_iter,
   input  wire fpces_word_t op_a,
   input  wire fpces_word_t op_b,
   // acceptance answer to the host core
   output logic             instr_accept,
   output logic             instr_bounce,
   // screened operands to the datapath
   output logic             opnd_valid,
   output fpces_word_t      opnd_a,
   output fpces_word_t      opnd_b,
   // result path from the datapath
   input  wire logic        res_valid,
   input  wire fpces_word_t res_raw,
   output logic             res_out_valid,
   output fpces_word_t      res_out_data,
   // interrupt
   output logic             irq
);

   fpces_op_e   op;
   logic        is_arith;
   fpces_word_t flush_a;
   fpces_word_t flush_b;
   logic [7:0]  exp_a;
   logic [7:0]  exp_b;
   logic        nan_a;
   logic        nan_b;
   logic        inf_a;
   logic        inf_b;
   logic        eff_sub;
   logic [7:0]  exp_max;
   logic [9:0]  prod_exp;
   logic [9:0]  quot_hi;
   logic [9:0]  quot_lo;
   logic        cond_inv;
   logic        cond_ovf;
   logic        cond_unf;
   logic [2:0]  cause_nxt;
   logic        pot_exc;
   logic        issue_ok;
   logic        take_exc;
   logic        trap_nxt;
   logic [2:0]  vec_len;
   logic        is_vector;
   fpces_word_t capture_nxt;
   logic        wait_r;
   logic        wr_fire;
   logic [31:0] rd_mux;
   logic [31:0] ctrl_r;
   logic        pend_r;
   logic        trap_r;
   logic [2:0]  cause_r;
   fpces_word_t instr_copy_r;
   logic [2:0]  istat_r;
   logic [2:0]  imask_r;
   logic [2:0]  ev_set;
   logic        accept_r;
   logic        bounce_r;
   logic        opnd_valid_r;
   fpces_word_t opnd_a_r;
   fpces_word_t opnd_b_r;
   logic        irq_r;
   logic        res_arith_r;

   // operation decode: copy, abs and neg move data but never compute
   assign op       = fpces_op_e'(instr_word[`FPCES_OP_MSB:`FPCES_OP_LSB]);
   assign is_arith = !(op == FPCES_OP_COPY || op == FPCES_OP_ABS || op == FPCES_OP_NEG);

   // operand screening with input flush
   fpces_operand_filter u_filt_a (
      .ftz     (ctrl_r[`FPCES_CTRL_FZ]),
      .opnd    (op_a),
      .flushed (flush_a),
      .exp_val (exp_a),
      .is_nan  (nan_a),
      .is_inf  (inf_a)
   );

   fpces_operand_filter u_filt_b (
      .ftz     (ctrl_r[`FPCES_CTRL_FZ]),
      .opnd    (op_b),
      .flushed (flush_b),
      .exp_val (exp_b),
      .is_nan  (nan_b),
      .is_inf  (inf_b)
   );

   // early judgement from exponents and signs only, long before a result exists
   assign eff_sub  = flush_a[`FPCES_SIGN_BIT] ^ flush_b[`FPCES_SIGN_BIT] ^ (op == FPCES_OP_SUB);
   assign exp_max  = (exp_a > exp_b) ? exp_a : exp_b;
   assign prod_exp = {2'b00, exp_a} + {2'b00, exp_b};
   assign quot_hi  = {2'b00, exp_a} + `FPCES_BIAS;
   assign quot_lo  = {2'b00, exp_b};

   // conservative screens: a false alarm only costs a trip through support code
   always_comb begin
      cond_inv = nan_a | nan_b | inf_a | inf_b;
      cond_ovf = 1'b0;
      cond_unf = 1'b0;
      case (op)
         FPCES_OP_ADD, FPCES_OP_SUB: begin
            cond_ovf = (exp_max >= `FPCES_OVF_ADD_EXP);
            cond_unf = eff_sub && (exp_max <= `FPCES_UNF_ADD_EXP);
         end
         FPCES_OP_MUL, FPCES_OP_MAC: begin
            cond_ovf = (prod_exp >= (`FPCES_OVF_LIMIT + `FPCES_BIAS));
            cond_unf = (prod_exp <= (`FPCES_UNF_LIMIT + `FPCES_BIAS));
         end
         FPCES_OP_DIV: begin
            cond_ovf = (quot_hi >= (quot_lo + `FPCES_OVF_LIMIT));
            cond_unf = (quot_hi <= (quot_lo + `FPCES_UNF_LIMIT));
         end
         default: begin
            cond_ovf = 1'b0;
            cond_unf = 1'b0;
         end
      endcase
   end

   assign cause_nxt = {cond_unf, cond_ovf, cond_inv};
   assign pot_exc   = is_arith && (cause_nxt != 3'h0);

   // issue outcome: while pending every trigger bounces
   assign issue_ok = instr_valid && !pend_r;
   assign take_exc = issue_ok && pot_exc;

   // trap only for conditions whose enable is set
   assign trap_nxt = (cond_inv && ctrl_r[`FPCES_CTRL_IOE]) ||
                     (cond_ovf && ctrl_r[`FPCES_CTRL_OFE]) ||
                     (cond_unf && ctrl_r[`FPCES_CTRL_UFE]);

   // short-vector rewrite: scalar when length is zero or destination is in bank 0
   assign vec_len   = ctrl_r[`FPCES_CTRL_LEN_MSB:`FPCES_CTRL_LEN_LSB];
   assign is_vector = (vec_len != 3'h0) &&
                      (instr_word[`FPCES_FD_MSB:`FPCES_FD_MSB-1] != `FPCES_BANK0);

   always_comb begin
      capture_nxt = instr_word;
      if (is_vector) begin
         // index wraps within the bank of eight, as the register banks do
         capture_nxt[`FPCES_FD_LSB+2:`FPCES_FD_LSB] =
            instr_word[`FPCES_FD_LSB+2:`FPCES_FD_LSB] + vec_iter;
         capture_nxt[`FPCES_FN_LSB+2:`FPCES_FN_LSB] =
            instr_word[`FPCES_FN_LSB+2:`FPCES_FN_LSB] + vec_iter;
         if (instr_word[`FPCES_FM_MSB:`FPCES_FM_MSB-1] != `FPCES_BANK0)
            capture_nxt[`FPCES_FM_LSB+2:`FPCES_FM_LSB] =
               instr_word[`FPCES_FM_LSB+2:`FPCES_FM_LSB] + vec_iter;
      end
   end

   // avalon handshake: one wait cycle per access, then waitrequest low for one edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         wait_r <= 1'b1;
      else
         wait_r <= !((avs_read || avs_write) && wait_r);
   end

   assign wr_fire = avs_write && !wait_r;

   always_comb begin
      case (avs_address)
         `FPCES_ADDR_CTRL:  rd_mux = ctrl_r;
         `FPCES_ADDR_EXC:   rd_mux = {pend_r, trap_r, 27'h0000000, cause_r};
         `FPCES_ADDR_INSTR: rd_mux = instr_copy_r;
         `FPCES_ADDR_ISTAT: rd_mux = {29'h00000000, istat_r};
         `FPCES_ADDR_IMASK: rd_mux = {29'h00000000, imask_r};
         default:           rd_mux = `FPCES_RDATA_ZERO;
      endcase
   end

   // read data loaded one edge ahead so they stand when waitrequest drops
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         avs_readdata <= `FPCES_RDATA_ZERO;
      else if (avs_read && wait_r)
         avs_readdata <= rd_mux;
   end

   assign avs_waitrequest = wait_r;

   // control register: enables, vector length, flush and default-NaN modes
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         ctrl_r <= `FPCES_CTRL_RST;
      else if (wr_fire && avs_address == `FPCES_ADDR_CTRL)
         ctrl_r <= avs_writedata & `FPCES_CTRL_WMASK;
   end

   // exceptional state: hardware entry wins over a software clear in the same cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pend_r  <= 1'b0;
         trap_r  <= 1'b0;
         cause_r <= 3'h0;
      end else if (take_exc) begin
         pend_r  <= 1'b1;
         trap_r  <= trap_nxt;
         cause_r <= cause_nxt;
      end else if (wr_fire && avs_address == `FPCES_ADDR_EXC) begin
         pend_r  <= avs_writedata[`FPCES_EXC_PEND];
         trap_r  <= avs_writedata[`FPCES_EXC_TRAP];
         cause_r <= avs_writedata[`FPCES_CAUSE_UNF:`FPCES_CAUSE_INV];
      end
   end

   // copy of the offending instruction for support software
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         instr_copy_r <= `FPCES_POS_ZERO;
      else if (take_exc)
         instr_copy_r <= capture_nxt;
   end

   // acceptance answer; a bounce is simply an issue that is not accepted
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         accept_r <= 1'b0;
         bounce_r <= 1'b0;
      end else begin
         accept_r <= issue_ok;
         bounce_r <= instr_valid && pend_r;
      end
   end

   // screened operands go to the datapath only for accepted issues
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         opnd_valid_r <= 1'b0;
         opnd_a_r     <= `FPCES_POS_ZERO;
         opnd_b_r     <= `FPCES_POS_ZERO;
         res_arith_r  <= 1'b0;
      end else begin
         opnd_valid_r <= issue_ok;
         if (issue_ok) begin
            opnd_a_r    <= is_arith ? flush_a : op_a;
            opnd_b_r    <= is_arith ? flush_b : op_b;
            res_arith_r <= is_arith;
         end
      end
   end

   // result conditioning for the last accepted operation
   fpces_result_filter u_res (
      .clk         (clk),
      .reset       (reset),
      .ftz         (ctrl_r[`FPCES_CTRL_FZ]),
      .dnan        (ctrl_r[`FPCES_CTRL_DN]),
      .arith       (res_arith_r),
      .res_valid   (res_valid),
      .res_raw     (res_raw),
      .res_valid_r (res_out_valid),
      .res_data_r  (res_out_data)
   );

   // interrupt events and sticky status, write one to clear, set wins
   assign ev_set = {take_exc && trap_nxt, instr_valid && pend_r, take_exc};

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         istat_r <= 3'h0;
      else if (wr_fire && avs_address == `FPCES_ADDR_ISTAT)
         istat_r <= (istat_r & ~avs_writedata[2:0]) | ev_set;
      else
         istat_r <= istat_r | ev_set;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         imask_r <= 3'h0;
      else if (wr_fire && avs_address == `FPCES_ADDR_IMASK)
         imask_r <= avs_writedata[2:0];
   end

   // level interrupt, one cycle behind the status bits
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         irq_r <= 1'b0;
      else
         irq_r <= |(istat_r & imask_r);
   end

   // registered outputs
   assign instr_accept = accept_r;
   assign instr_bounce = bounce_r;
   assign opnd_valid   = opnd_valid_r;
   assign opnd_a       = opnd_a_r;
   assign opnd_b       = opnd_b_r;
   assign irq          = irq_r;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_move_not_exc: assert property (
      instr_valid && !pend_r && !is_arith |=> !pend_r)
      else $error("copy/abs/neg entered exceptional state");

   a_bounce_no_accept: assert property (
      instr_valid && pend_r |=> bounce_r && !accept_r)
      else $error("bounced issue was accepted");

   a_disabled_no_trap: assert property (
      take_exc && !trap_nxt |=> pend_r && !trap_r && !$rose(istat_r[`FPCES_IRQ_TRAP]))
      else $error("trap raised for disabled condition");

   a_enabled_trap: assert property (
      take_exc && cond_inv && ctrl_r[`FPCES_CTRL_IOE] |=> trap_r && istat_r[`FPCES_IRQ_TRAP])
      else $error("enabled condition did not trap");

   a_pend_capture: assert property (
      take_exc && !is_vector |=> pend_r && instr_copy_r == $past(instr_word))
      else $error("capture on exception entry wrong");

   a_vec_rewrite: assert property (
      take_exc && is_vector |=> instr_copy_r[`FPCES_FD_LSB+2:`FPCES_FD_LSB] ==
         $past(instr_word[`FPCES_FD_LSB+2:`FPCES_FD_LSB]) + $past(vec_iter))
      else $error("vector iteration not encoded");

   a_pend_holds: assert property (
      pend_r && !(wr_fire && avs_address == `FPCES_ADDR_EXC) |=> pend_r && !accept_r)
      else $error("pending dropped without software");

   a_ftz_input: assert property (
      issue_ok && is_arith && ctrl_r[`FPCES_CTRL_FZ] && op_a[`FPCES_EXP_MSB:`FPCES_EXP_LSB] == `FPCES_EXP_ZERO
      |=> opnd_a_r[`FPCES_SIGN_BIT-1:0] == 31'h00000000 &&
          !(opnd_a_r[`FPCES_SIGN_BIT] && $past(op_a[`FPCES_FRAC_MSB:0]) != `FPCES_FRAC_ZERO))
      else $error("subnormal input not flushed");

   a_nan_invalid: assert property (
      issue_ok && is_arith && nan_a |=> pend_r && cause_r[`FPCES_CAUSE_INV])
      else $error("NaN operand not judged invalid");

   c_enter_exc: cover property (take_exc ##1 instr_valid);
   c_trap_irq: cover property (take_exc && trap_nxt ##[1:4] irq_r);
   c_sw_clear: cover property (pend_r ##1 !pend_r);

endmodule : fpces_exception_unit

// [common/fpces_regs.svh]
// Purpose: register map, field positions and thresholds of the fp exception-state unit
// Assumes: 32-bit Avalon-MM slave, byte addresses, one register per aligned word
// Notes:   single-precision encodings drive the operand screening and result filtering
// Behaviour
// - Every data-processing op is arithmetic except copy, absolute value and negate.
// - A bounce means acceptance is withheld; the host then runs undefined-instruction handling.
// - In default-NaN mode any NaN result becomes the single default NaN.
// - A condition with its enable clear raises no user trap.
// - A condition with its enable set leads to a trap to the user handler.
// - A potentially exceptional issue sets pending bit 31 and captures the instruction.
// - For short vectors the captured register fields name the exceptional iteration.
// - While pending is set every trigger instruction is bounced.
// - Flush-to-zero turns subnormal arithmetic inputs into positive zero.
// - Flush-to-zero turns subnormal pre-rounding results into positive zero, except computed zeros.
// - Destination field is result and accumulate input; two source fields give the rest.
// - Potential exceptions are judged from operand exponents and signs before computing.
`ifndef FPCES_REGS_SVH
`define FPCES_REGS_SVH

// register byte addresses
`define FPCES_ADDR_CTRL     5'h00
`define FPCES_ADDR_EXC      5'h04
`define FPCES_ADDR_INSTR    5'h08
`define FPCES_ADDR_ISTAT    5'h0C
`define FPCES_ADDR_IMASK    5'h10

// status/control fields
`define FPCES_CTRL_IOE      0
`define FPCES_CTRL_OFE      2
`define FPCES_CTRL_UFE      3
`define FPCES_CTRL_LEN_LSB  16
`define FPCES_CTRL_LEN_MSB  18
`define FPCES_CTRL_FZ       24
`define FPCES_CTRL_DN       25
`define FPCES_CTRL_WMASK    32'h0307000D
`define FPCES_CTRL_RST      32'h00000000

// exception register fields; cause bits: invalid, overflow, underflow
`define FPCES_EXC_PEND      31
`define FPCES_EXC_TRAP      30
`define FPCES_CAUSE_INV     0
`define FPCES_CAUSE_OVF     1
`define FPCES_CAUSE_UNF     2

// interrupt status bits
`define FPCES_IRQ_ENTER     0
`define FPCES_IRQ_BOUNCE    1
`define FPCES_IRQ_TRAP      2

// instruction fields
`define FPCES_OP_MSB        31
`define FPCES_OP_LSB        28
`define FPCES_PREC_BIT      27
`define FPCES_FN_MSB        26
`define FPCES_FN_LSB        22
`define FPCES_FD_MSB        21
`define FPCES_FD_LSB        17
`define FPCES_FM_MSB        4
`define FPCES_FM_LSB        0
`define FPCES_BANK0         2'h0

// single-precision encodings and screening thresholds
`define FPCES_SIGN_BIT      31
`define FPCES_EXP_MSB       30
`define FPCES_EXP_LSB       23
`define FPCES_FRAC_MSB      22
`define FPCES_EXP_MAX       8'hFF
`define FPCES_EXP_ZERO      8'h00
`define FPCES_FRAC_ZERO     23'h000000
`define FPCES_POS_ZERO      32'h00000000
`define FPCES_DEFAULT_NAN   32'h7FC00000
`define FPCES_BIAS          10'h07F
`define FPCES_OVF_ADD_EXP   8'hFE
`define FPCES_UNF_ADD_EXP   8'h18
`define FPCES_OVF_LIMIT     10'h0FE
`define FPCES_UNF_LIMIT     10'h001
`define FPCES_RDATA_ZERO    32'h00000000

`endif

// [common/fpces_pkg.sv]
// Purpose: shared types of the fp exception-state unit
// Assumes: operation codes sit in the top nibble of the issued word
// Notes:   codes 8 to F are spare and are treated as arithmetic ops, but screened only for invalid operands, never for overflow or underflow
package fpces_pkg;

   // data-processing operations
   typedef enum logic [3:0] {
      FPCES_OP_COPY = 4'h0,
      FPCES_OP_ABS  = 4'h1,
      FPCES_OP_NEG  = 4'h2,
      FPCES_OP_ADD  = 4'h3,
      FPCES_OP_SUB  = 4'h4,
      FPCES_OP_MUL  = 4'h5,
      FPCES_OP_DIV  = 4'h6,
      FPCES_OP_MAC  = 4'h7
   } fpces_op_e;

   typedef logic [31:0] fpces_word_t;

endpackage : fpces_pkg

// [core/fpces_operand_filter.sv]
// Purpose: classify one single-precision operand and apply input flush-to-zero
// Assumes: purely combinational, registered by the caller
// Notes:   a flushed operand is reported with a zero exponent
`timescale 1ns/1ns
`include "fpces_regs.svh"
module fpces_operand_filter
   import fpces_pkg::*;
(
   // control
   input  wire logic        ftz,
   // operand
   input  wire fpces_word_t opnd,
   // screened view
   output fpces_word_t      flushed,
   output logic [7:0]       exp_val,
   output logic             is_nan,
   output logic             is_inf
);

   logic        exp_zero;
   logic        frac_zero;
   logic        exp_full;

   // field decode of the raw operand
   assign exp_zero  = (opnd[`FPCES_EXP_MSB:`FPCES_EXP_LSB] == `FPCES_EXP_ZERO);
   assign exp_full  = (opnd[`FPCES_EXP_MSB:`FPCES_EXP_LSB] == `FPCES_EXP_MAX);
   assign frac_zero = (opnd[`FPCES_FRAC_MSB:0] == `FPCES_FRAC_ZERO);
   assign is_nan    = exp_full & ~frac_zero;
   assign is_inf    = exp_full & frac_zero;

   // subnormal magnitude becomes +0, the sign is dropped on purpose
   assign flushed = (ftz && exp_zero && !frac_zero) ? `FPCES_POS_ZERO : opnd;
   assign exp_val = flushed[`FPCES_EXP_MSB:`FPCES_EXP_LSB];

endmodule : fpces_operand_filter

// [core/fpces_result_filter.sv]
// Purpose: final result conditioning for flush-to-zero and default-NaN modes
// Assumes: raw result arrives unrounded from the arithmetic datapath
// Notes:   one cycle of latency, output held until the next valid result
`timescale 1ns/1ns
`include "fpces_regs.svh"
module fpces_result_filter
   import fpces_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // mode
   input  wire logic        ftz,
   input  wire logic        dnan,
   input  wire logic        arith,
   // raw result
   input  wire logic        res_valid,
   input  wire fpces_word_t res_raw,
   // conditioned result
   output logic             res_valid_r,
   output fpces_word_t      res_data_r
);

   logic        r_exp_zero;
   logic        r_exp_full;
   logic        r_frac_zero;

   assign r_exp_zero  = (res_raw[`FPCES_EXP_MSB:`FPCES_EXP_LSB] == `FPCES_EXP_ZERO);
   assign r_exp_full  = (res_raw[`FPCES_EXP_MSB:`FPCES_EXP_LSB] == `FPCES_EXP_MAX);
   assign r_frac_zero = (res_raw[`FPCES_FRAC_MSB:0] == `FPCES_FRAC_ZERO);

   // NaN wins over flushing; a computed zero keeps its sign
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         res_valid_r <= 1'b0;
         res_data_r  <= `FPCES_POS_ZERO;
      end else begin
         res_valid_r <= res_valid;
         if (res_valid) begin
            if (dnan && r_exp_full && !r_frac_zero)
               res_data_r <= `FPCES_DEFAULT_NAN;
            else if (ftz && arith && r_exp_zero && !r_frac_zero)
               res_data_r <= `FPCES_POS_ZERO;
            else
               res_data_r <= res_raw;
         end
      end
   end

   a_default_nan: assert property (@(posedge clk) disable iff (reset)
      res_valid && dnan && r_exp_full && !r_frac_zero |=> res_data_r == `FPCES_DEFAULT_NAN)
      else $error("default NaN not returned");

   a_no_subnormal: assert property (@(posedge clk) disable iff (reset)
      res_valid && ftz && arith && r_exp_zero |=>
         res_data_r[`FPCES_FRAC_MSB:0] == `FPCES_FRAC_ZERO)
      else $error("subnormal result produced in flush mode");

endmodule : fpces_result_filter

// [verification/fpces_host_model.sv]
// Purpose: host core model that issues coprocessor instructions
// Assumes: one issue per call, answer sampled by the caller
// Notes:   released lines carry the inverse of the last value, vec_iter keeps it
`timescale 1ns/1ns
module fpces_host_model
   import fpces_pkg::*;
(
   // clock
   input  wire logic        clk,
   // answer from the coprocessor
   input  wire logic        instr_bounce,
   // issue lines
   output logic             instr_valid,
   output fpces_word_t      instr_word,
   output logic [2:0]       vec_iter,
   output fpces_word_t      op_a,
   output fpces_word_t      op_b
);
   int n_undef = 0;

   // quiet lines at time zero
   initial begin
      instr_valid = 1'b0;
      instr_word  = 32'h00000000;
      vec_iter    = 3'h0;
      op_a        = 32'h00000000;
      op_b        = 32'h00000000;
   end

   // one-cycle issue, then the stale word and operands are scrambled so nothing leans on them
   task send(input fpces_word_t w, input fpces_word_t a, input fpces_word_t b, input logic [2:0] it);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word  <= w;
      op_a        <= a;
      op_b        <= b;
      vec_iter    <= it;
      @(posedge clk);
      instr_valid <= 1'b0;
      instr_word  <= ~w;
      op_a        <= ~a;
      op_b        <= ~b;
   endtask : send

   // a withheld acceptance sends the host to undefined-instruction handling
   always @(posedge clk) if (instr_bounce === 1'b1) n_undef <= n_undef + 1;
endmodule : fpces_host_model

// [verification/fpces_exception_unit_tb.sv]
// Purpose: self-checking bench of the fp exception-state unit
// Assumes: host model issues, bench drives avalon and the result path
// Notes:   expectations from header constants, operands from an lfsr
`timescale 1ns/1ns
`include "fpces_regs.svh"
module fpces_exception_unit_tb
   import fpces_pkg::*;
;
   logic        clk, reset, avs_read, avs_write, avs_waitrequest, instr_valid, instr_accept;
   logic        instr_bounce, opnd_valid, res_valid, res_out_valid, irq;
   logic [4:0]  avs_address;
   logic [2:0]  vec_iter;
   logic [31:0] avs_writedata, avs_readdata, r, seed;
   fpces_word_t instr_word, op_a, op_b, opnd_a, opnd_b, res_raw, res_out_data, w, a;
   int          n_errors = 0, check_count = 0, cyc = 0;
   localparam fpces_word_t NAN = 32'h7FA00001, ONE = 32'h3F800000;

   fpces_exception_unit fpces_exception_unit_i (.clk(clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .instr_valid(instr_valid), .instr_word(instr_word),
      .vec_iter(vec_iter), .op_a(op_a), .op_b(op_b), .instr_accept(instr_accept),
      .instr_bounce(instr_bounce), .opnd_valid(opnd_valid), .opnd_a(opnd_a), .opnd_b(opnd_b),
      .res_valid(res_valid), .res_raw(res_raw), .res_out_valid(res_out_valid),
      .res_out_data(res_out_data), .irq(irq));
   fpces_host_model fpces_host_model_i (.clk(clk), .instr_bounce(instr_bounce), .instr_valid(instr_valid),
      .instr_word(instr_word), .vec_iter(vec_iter), .op_a(op_a), .op_b(op_b));

   // clock and hang guard; the run needs well under a thousand cycles
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic fpces_word_t wrd(input logic [3:0] op, input logic [4:0] d, input logic [4:0] n,
                                       input logic [4:0] m);
      return {op, 1'b0, n, d, 12'h000, m};
   endfunction : wrd

   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // avalon access held until waitrequest is seen low at an edge; a hang is left to the bench timeout
   task av(input logic wr, input logic [4:0] ad, input logic [31:0] d);
      @(posedge clk);
      avs_read      <= !wr;
      avs_write     <= wr;
      avs_address   <= ad;
      avs_writedata <= d;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : av
   task rd(input logic [4:0] ad, input logic [31:0] e);
      av(1'b0, ad, 32'h00000000);
      chk(r, e);
   endtask : rd
   // answer is a registered pulse in the cycle after issue
   task iss(input fpces_word_t iw, input fpces_word_t x, input fpces_word_t y, input logic [2:0] it,
            input logic acc);
      fpces_host_model_i.send(iw, x, y, it);
      #1;
      chk({29'h0, opnd_valid, instr_accept, instr_bounce}, acc ? 32'h6 : 32'h1);
   endtask : iss
   task res(input fpces_word_t v, input fpces_word_t e);
      @(posedge clk);
      res_valid <= 1'b1;
      res_raw   <= v;
      @(posedge clk);
      res_valid <= 1'b0;
      res_raw   <= ~v;
      #1;
      chk({res_out_valid, res_out_data}, {1'b1, e});
   endtask : res
   task conclude;
      $display("counts: %0d checks, %0d mismatches", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   initial begin
      {reset, avs_read, avs_write, res_valid} = 4'h8;
      {avs_address, avs_writedata, res_raw} = '0;
      seed = 32'hFE9A037A;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      // reset values and an unmapped word
      av(1'b1, 5'h14, 32'hFFFFFFFF);
      for (int i = 0; i < 6; i++) rd(5'(i * 4), 32'h00000000);
      av(1'b1, `FPCES_ADDR_CTRL, 32'hFFFFFFFF);
      rd(`FPCES_ADDR_CTRL, `FPCES_CTRL_WMASK);
      $display("test 1 done");
      // op codes 0 to 7; NaN into copy, abs and negate is not screened
      av(1'b1, `FPCES_ADDR_CTRL, 32'h00000000);
      for (int i = 0; i < 8; i++) begin
         iss(wrd(4'(i), 5'h02, 5'h03, 5'h04), (i < 3) ? NAN : ONE, ONE, 3'h0, 1'b1);
         rd(`FPCES_ADDR_EXC, 32'h00000000);
      end
      $display("test 2 done");
      // disabled invalid: entry, capture, then the next trigger bounces
      av(1'b1, `FPCES_ADDR_IMASK, 32'h00000007);
      w = wrd(4'h3, 5'h02, 5'h03, 5'h04);
      iss(w, NAN, ONE, 3'h0, 1'b1);
      rd(`FPCES_ADDR_EXC, 32'h80000003);
      rd(`FPCES_ADDR_INSTR, w);
      chk({31'h0, irq}, 32'h1);
      iss(wrd(4'h5, 5'h01, 5'h01, 5'h01), ONE, ONE, 3'h0, 1'b0);
      rd(`FPCES_ADDR_ISTAT, 32'h00000003);
      chk(fpces_host_model_i.n_undef, 32'h1);
      av(1'b1, `FPCES_ADDR_EXC, 32'h00000000);
      av(1'b1, `FPCES_ADDR_ISTAT, 32'h00000007);
      @(posedge clk);
      #1;
      chk({31'h0, irq}, 32'h0);
      iss(w, ONE, ONE, 3'h0, 1'b1);
      $display("test 3 done");
      // enabled invalid inside a short vector at iteration 3
      av(1'b1, `FPCES_ADDR_CTRL, 32'h00010001);
      iss(wrd(4'h7, 5'h0A, 5'h0B, 5'h01), ONE, NAN, 3'h3, 1'b1);
      rd(`FPCES_ADDR_EXC, 32'hC0000003);
      rd(`FPCES_ADDR_INSTR, wrd(4'h7, 5'h0D, 5'h0E, 5'h01));
      rd(`FPCES_ADDR_ISTAT, 32'h00000005);
      av(1'b1, `FPCES_ADDR_EXC, 32'h00000000);
      av(1'b1, `FPCES_ADDR_ISTAT, 32'h00000007);
      // enabled underflow on a product of small exponents
      av(1'b1, `FPCES_ADDR_CTRL, 32'h00000008);
      iss(wrd(4'h5, 5'h01, 5'h02, 5'h03), 32'h00800000, ONE, 3'h0, 1'b1);
      rd(`FPCES_ADDR_EXC, 32'hC0000004);
      rd(`FPCES_ADDR_ISTAT, 32'h00000005);
      av(1'b1, `FPCES_ADDR_EXC, 32'h00000000);
      av(1'b1, `FPCES_ADDR_ISTAT, 32'h00000007);
      $display("test 4 done");
      // flush-to-zero and default NaN with random subnormals and payloads
      av(1'b1, `FPCES_ADDR_CTRL, 32'h03000000);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         a = {seed[31], 8'h00, seed[22:0] | 23'h1};
         iss(wrd(4'h3, 5'h02, 5'h03, 5'h04), a, ONE, 3'h0, 1'b1);
         chk(opnd_a, `FPCES_POS_ZERO);
         chk(opnd_b, ONE);
         res(a, `FPCES_POS_ZERO);
         res({seed[31], 8'hFF, seed[22:0] | 23'h1}, `FPCES_DEFAULT_NAN);
      end
      $display("test 5 done");
      conclude();
   end
endmodule : fpces_exception_unit_tb
